/* File: src/tmc_timer.sv */
// 16-bit timer/counter: normal and clear-on-match counting, compare units, flags
// assumes a synchronous register master with one-cycle strobes; pins are external
`timescale 1ns/1ps
`include "tmc_regs.svh"

module tmc_timer (
   input wire logic clock,
   input wire logic reset,
   input wire tmc_pkg::tmc_bus_t bus,
   output logic [15:0] rdata,
   input wire logic ovfIntAck,
   input wire logic captureEvent,
   input wire logic portOutA,
   input wire logic portOutB,
   input wire logic pinDirA,
   input wire logic pinDirB,
   output logic pinOutA,
   output logic pinOutEnA_n,
   output logic pinOutB,
   output logic pinOutEnB_n
);
   import tmc_pkg::*;

   // ----------------------------------------
   // pin input synchronisers
   // ----------------------------------------
   logic [4:0] sync1_q; // first stage, read only by second
   logic [4:0] sync2_q; // second stage
   logic captPrev_q; // last captured event level

   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {captureEvent, portOutA, portOutB, pinDirA, pinDirB};
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [15:0] ctrl_q; // clock select, waveform and compare modes
   logic [1:0] outSel_q; // pin_output_select bits
   logic [15:0] count_q; // counter_value
   logic [15:0] count_d;
   logic [15:0] cmpA_q; // compare_a_value, unbuffered here
   logic [15:0] cmpB_q; // compare b value
   logic [15:0] capt_q; // capture_value
   logic [3:0] flags_q; // overflow, compare a, compare b, capture
   logic [3:0] flags_d;
   logic [9:0] pre_q; // prescaler count
   logic block_q; // match blocked in coming tick
   logic pendA_q; // compare a match seen, flag next tick
   logic pendB_q; // compare b match seen, flag next tick

   // field decode
   wire [2:0] clkSel = ctrl_q[`TMC_CTRL_CS_LSB +: 3];
   wire [3:0] wgm = ctrl_q[`TMC_CTRL_WGM_LSB +: 4];
   wire tmc_com_t comA = tmc_com_t'(ctrl_q[`TMC_CTRL_COMA_LSB +: 2]);
   wire tmc_com_t comB = tmc_com_t'(ctrl_q[`TMC_CTRL_COMB_LSB +: 2]);

   // strobe decode
   function automatic logic hit(input tmc_bus_t b, input logic [3:0] a);
      hit = b.wr && (b.addr == a);
   endfunction

   wire wrCtrl = hit(bus, `TMC_ADDR_CTRL);
   wire wrSel = hit(bus, `TMC_ADDR_OUTSEL);
   wire wrCount = hit(bus, `TMC_ADDR_COUNT);
   wire wrCmpA = hit(bus, `TMC_ADDR_CMPA);
   wire wrCmpB = hit(bus, `TMC_ADDR_CMPB);
   wire wrCapt = hit(bus, `TMC_ADDR_CAPT);
   wire wrFlags = hit(bus, `TMC_ADDR_FLAGS);
   wire wrForce = hit(bus, `TMC_ADDR_FORCE);
   wire wrState = hit(bus, `TMC_ADDR_STATE);

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   logic [9:0] preLimit; // terminal count of prescaler
   logic running; // clock select 1 to 5
   logic tick; // one timer clock cycle

   // divide factors 1, 8, 64, 256, 1024; other codes stop
   assign preLimit = (clkSel == 3'h2) ? `TMC_DIV_8 :
                     (clkSel == 3'h3) ? `TMC_DIV_64 :
                     (clkSel == 3'h4) ? `TMC_DIV_256 :
                     (clkSel == 3'h5) ? `TMC_DIV_1024 : 10'h000;
   assign running = (clkSel != 3'h0) && (clkSel <= 3'h5);
   assign tick = running && (pre_q == preLimit);

   always_ff @(posedge clock) begin
      if (reset || !running || tick) begin
         pre_q <= 10'h000;
      end else begin
         pre_q <= pre_q + 10'h001;
      end
   end

   // ----------------------------------------
   // counter and match logic
   // ----------------------------------------
   logic ctcMode; // clear on match mode
   logic [15:0] topVal; // top value in clear mode
   logic matchA; // comparator a equal
   logic matchB; // comparator b equal
   logic atTop; // counter equals top in clear mode
   logic wrap; // counter passes max to zero
   logic nonPwm; // force allowed

   // counting is steered by waveform mode alone
   assign ctcMode = (wgm == `TMC_WGM_CTC_A) || (wgm == `TMC_WGM_CTC_CAPT);
   assign nonPwm = (wgm == `TMC_WGM_NORMAL) || ctcMode;
   // top taken straight from unbuffered register
   assign topVal = (wgm == `TMC_WGM_CTC_A) ? cmpA_q : capt_q;
   // a counter write blocks matches in the next tick
   assign matchA = (count_q == cmpA_q) && !block_q;
   assign matchB = (count_q == cmpB_q) && !block_q;
   assign atTop = ctcMode && (count_q == topVal) && !block_q;
   assign wrap = (count_q == `TMC_COUNT_MAX);

   // next count: write wins anytime, else clear at top or step up
   assign count_d = wrCount ? bus.wdata :
                    !tick ? count_q :
                    atTop ? `TMC_COUNT_BOTTOM :
                    count_q + 16'h0001;

   always_ff @(posedge clock) begin
      if (reset) begin
         count_q <= `TMC_COUNT_BOTTOM;
         block_q <= 1'b0;
         pendA_q <= 1'b0;
         pendB_q <= 1'b0;
      end else begin
         count_q <= count_d;
         // hold the block until a tick has consumed it
         block_q <= wrCount ? 1'b1 : (tick ? 1'b0 : block_q);
         pendA_q <= tick ? matchA : pendA_q & ~tick;
         pendB_q <= tick ? matchB : pendB_q & ~tick;
      end
   end

   // ----------------------------------------
   // flags: set wins over clear
   // ----------------------------------------
   logic setOvf; // overflow event
   logic setA; // compare a flag event
   logic setB; // compare b flag event
   logic setCapt; // capture event or top match via capture register
   logic captEdge; // rising capture input

   // overflow when counter becomes zero from max
   assign setOvf = tick && wrap && !wrCount;
   // compare flags land one tick after the equal cycle
   assign setA = tick && pendA_q;
   assign setB = tick && pendB_q;
   assign captEdge = sync2_q[4] && !captPrev_q;
   // capture flag also marks top when capture register defines it
   assign setCapt = captEdge || (tick && atTop && (wgm == `TMC_WGM_CTC_CAPT));
   assign flags_d = (flags_q & ~(wrFlags ? bus.wdata[3:0] : 4'h0)
                     & ~{3'h0, ovfIntAck})
                    | {setCapt, setB, setA, setOvf};

   always_ff @(posedge clock) begin
      if (reset) begin
         flags_q <= 4'h0;
         captPrev_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         captPrev_q <= sync2_q[4];
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   logic [15:0] captVal_d; // capture register next value

   // capture path never reads the compare output mode
   assign captVal_d = captEdge ? count_q : (wrCapt ? bus.wdata : capt_q);

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_q <= `TMC_CTRL_RESET;
         outSel_q <= 2'b00;
         cmpA_q <= 16'h0000;
         cmpB_q <= 16'h0000;
         capt_q <= 16'h0000;
      end else begin
         // new mode bits take effect from the next clock edge
         ctrl_q <= wrCtrl ? bus.wdata : ctrl_q;
         outSel_q <= wrSel ? bus.wdata[1:0] : outSel_q;
         cmpA_q <= wrCmpA ? bus.wdata : cmpA_q;
         cmpB_q <= wrCmpB ? bus.wdata : cmpB_q;
         capt_q <= captVal_d;
      end
   end

   // ----------------------------------------
   // compare output units
   // ----------------------------------------
   logic actA; // match or force on channel a
   logic actB; // match or force on channel b
   logic stateA; // compare_output_state a
   logic stateB; // compare_output_state b
   logic [15:0] rdata_d; // read mux

   // a force strobe acts at once, without flag or clear, non-PWM only
   assign actA = (tick && matchA) || (wrForce && nonPwm && bus.wdata[0]);
   assign actB = (tick && matchB) || (wrForce && nonPwm && bus.wdata[1]);

   tmc_out_unit outA (
      .clock(clock),
      .reset(reset),
      .setState(wrState),
      .stateValue(bus.wdata[0]),
      .act(actA),
      .mode(comA),
      .pinOutputSelect(outSel_q[`TMC_SEL_A]),
      .pinIn('{portOut: sync2_q[3], direction: sync2_q[1]}),
      .stateOut(stateA),
      .pinOut(pinOutA),
      .pinOutEn_n(pinOutEnA_n)
   );

   tmc_out_unit outB (
      .clock(clock),
      .reset(reset),
      .setState(wrState),
      .stateValue(bus.wdata[1]),
      .act(actB),
      .mode(comB),
      .pinOutputSelect(outSel_q[`TMC_SEL_B]),
      .pinIn('{portOut: sync2_q[2], direction: sync2_q[0]}),
      .stateOut(stateB),
      .pinOut(pinOutB),
      .pinOutEn_n(pinOutEnB_n)
   );

   // ----------------------------------------
   // read port, data one cycle after strobe
   // ----------------------------------------
   assign rdata_d = !bus.rd ? 16'h0000 :
                    (bus.addr == `TMC_ADDR_CTRL) ? ctrl_q :
                    (bus.addr == `TMC_ADDR_OUTSEL) ? {14'h0000, outSel_q} :
                    (bus.addr == `TMC_ADDR_COUNT) ? count_q :
                    (bus.addr == `TMC_ADDR_CMPA) ? cmpA_q :
                    (bus.addr == `TMC_ADDR_CMPB) ? cmpB_q :
                    (bus.addr == `TMC_ADDR_CAPT) ? capt_q :
                    (bus.addr == `TMC_ADDR_FLAGS) ? {12'h000, flags_q} :
                    (bus.addr == `TMC_ADDR_STATE) ? {14'h0000, stateB, stateA} :
                    16'h0000;

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= rdata_d;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // long waits are split into short steps through the pending bits, so
   // no property needs an open-ended repetition while the timer is slow
   sequence s_ctc_top;
      tick && atTop && !wrCount;
   endsequence

   sequence s_match_a;
      tick && matchA;
   endsequence

   sequence s_div8_gap;
      ##1 !tick [*7] ##1 tick;
   endsequence

   // top match restarts the count at bottom
   a_ctc_clear_top: assert property (@(posedge clock) disable iff (reset)
      s_ctc_top |=> (count_q == 16'h0000))
      else $error("clear mode did not clear at top");
   // free running count steps by one and wraps at max
   a_normal_wrap: assert property (@(posedge clock) disable iff (reset)
      (tick && wgm == 4'h0 && !wrCount) |=> (count_q == $past(count_q) + 16'h0001))
      else $error("normal mode did not step by one");
   // overflow lands with the wrap tick
   a_overflow_set: assert property (@(posedge clock) disable iff (reset)
      (tick && count_q == 16'hffff && !wrCount) |=> flags_q[0])
      else $error("overflow flag not set on wrap");
   // a matching tick arms the delayed flag
   a_match_flag_delay: assert property (@(posedge clock) disable iff (reset)
      s_match_a |=> pendA_q)
      else $error("compare match not held for the next tick");
   // the armed match sets the flag at the following tick
   a_match_flag_set: assert property (@(posedge clock) disable iff (reset)
      (tick && pendA_q) |=> flags_q[1])
      else $error("compare flag not set one tick later");
   // counter write hides the next tick's matches
   a_block_after_write: assert property (@(posedge clock) disable iff (reset)
      wrCount |=> !matchA && !matchB)
      else $error("match not blocked after counter write");
   // force strobe never reaches the flag
   a_force_no_flag: assert property (@(posedge clock) disable iff (reset)
      (wrForce && !tick && !pendA_q && !flags_q[1] && !wrFlags) |=> !flags_q[1])
      else $error("force set the compare flag");
   // taken interrupt drops the overflow flag
   a_ack_clears_ovf: assert property (@(posedge clock) disable iff (reset)
      (ovfIntAck && !setOvf) |=> !flags_q[0])
      else $error("overflow flag not cleared on acknowledge");
   // a control write may stop the divider mid period, so it aborts the check
   a_prescale_period: assert property (@(posedge clock) disable iff (reset || wrCtrl)
      (tick && clkSel == 3'h2 && !wrCtrl) |-> s_div8_gap)
      else $error("divide by eight period wrong");
   // software count lands on the next edge
   a_count_write: assert property (@(posedge clock) disable iff (reset)
      wrCount |=> (count_q == $past(bus.wdata)))
      else $error("counter write not taken");
endmodule // tmc_timer

/* File: src/tmc_regs.svh */
// register offsets, field positions, reset values and timing counts for the timer block
// assumes a plain register port with 4-bit word addresses and 16-bit data
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// ----------------------------------------
// register offsets (word addresses)
// ----------------------------------------
`define TMC_ADDR_CTRL 4'h0
`define TMC_ADDR_OUTSEL 4'h1
`define TMC_ADDR_COUNT 4'h2
`define TMC_ADDR_CMPA 4'h3
`define TMC_ADDR_CMPB 4'h4
`define TMC_ADDR_CAPT 4'h5
`define TMC_ADDR_FLAGS 4'h6
`define TMC_ADDR_FORCE 4'h7
`define TMC_ADDR_STATE 4'h8

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TMC_CTRL_CS_LSB 0
`define TMC_CTRL_WGM_LSB 4
`define TMC_CTRL_COMA_LSB 8
`define TMC_CTRL_COMB_LSB 10
`define TMC_CTRL_RESET 16'h0000

// ----------------------------------------
// flag and output select bit positions
// ----------------------------------------
`define TMC_FLAG_OVF 0
`define TMC_FLAG_CMPA 1
`define TMC_FLAG_CMPB 2
`define TMC_FLAG_CAPT 3
`define TMC_SEL_A 0
`define TMC_SEL_B 1

// ----------------------------------------
// modes and prescale counts
// ----------------------------------------
`define TMC_WGM_NORMAL 4'h0
`define TMC_WGM_CTC_A 4'h4
`define TMC_WGM_CTC_CAPT 4'hc
`define TMC_COUNT_MAX 16'hffff
`define TMC_COUNT_BOTTOM 16'h0000
`define TMC_DIV_8 10'h007
`define TMC_DIV_64 10'h03f
`define TMC_DIV_256 10'h0ff
`define TMC_DIV_1024 10'h3ff

`endif

/* File: src/tmc_pkg.sv */
// types shared by the timer block
// assumes tmc_regs.svh supplies all numeric constants
package tmc_pkg;

   // ----------------------------------------
   // register port carrier
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] addr; // word address
      logic [15:0] wdata; // write data
      logic wr; // write strobe
      logic rd; // read strobe
   } tmc_bus_t;

   // compare output actions for non-PWM modes
   typedef enum logic [1:0] {
      TMC_COM_NONE = 2'b00,
      TMC_COM_TOGGLE = 2'b01,
      TMC_COM_CLEAR = 2'b10,
      TMC_COM_SET = 2'b11
   } tmc_com_t;

   // pin-side signals of one compare channel
   typedef struct packed {
      logic portOut; // general port output bit
      logic direction; // compare_pin_direction, 1 = output
   } tmc_pin_t;

endpackage

/* File: src/tmc_out_unit.sv */
// compare output unit: holds one compare_output_state bit and its pin override
// assumes a match/force pulse from the counter core on the same clock
`timescale 1ns/1ps
`include "tmc_regs.svh"

module tmc_out_unit (
   input wire logic clock,
   input wire logic reset,
   input wire logic setState,
   input wire logic stateValue,
   input wire logic act,
   input wire tmc_pkg::tmc_com_t mode,
   input wire logic pinOutputSelect,
   input wire tmc_pkg::tmc_pin_t pinIn,
   output logic stateOut,
   output logic pinOut,
   output logic pinOutEn_n
);
   import tmc_pkg::*;

   // ----------------------------------------
   // compare output state
   // ----------------------------------------
   logic state_q; // compare_output_state
   logic state_d; // next state
   logic actResult; // state after a match action
   logic override; // port override active
   logic pinVal_d; // next pin level

   // non-PWM actions; mode zero leaves the state alone
   assign actResult = (mode == TMC_COM_TOGGLE) ? ~state_q :
                      (mode == TMC_COM_CLEAR) ? 1'b0 :
                      (mode == TMC_COM_SET) ? 1'b1 : state_q;
   // software load lets the pin start at a known level
   assign state_d = setState ? stateValue : (act ? actResult : state_q);
   // override only with nonzero mode and the select bit set
   assign override = (mode != TMC_COM_NONE) && pinOutputSelect;
   assign pinVal_d = override ? state_d : pinIn.portOut;

   // state register, cleared on reset
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= 1'b0;
         pinOut <= 1'b0;
         pinOutEn_n <= 1'b1;
      end else begin
         state_q <= state_d;
         pinOut <= pinVal_d;
         // direction stays with the port bit
         pinOutEn_n <= ~pinIn.direction;
      end
   end

   assign stateOut = state_q;

   a_state_reset: assert property (@(posedge clock) reset |=> !state_q)
      else $error("output state not cleared by reset");
   a_mode_zero_hold: assert property (@(posedge clock) disable iff (reset)
      (act && !setState && mode == TMC_COM_NONE) |=> $stable(state_q))
      else $error("mode zero changed the output state");
endmodule // tmc_out_unit

/* File: sim/tmc_timer_bench.sv */
// self-checking bench for the timer block: register port, compare output pins, counting modes
// assumes the register map of tmc_regs.svh and two-flop synchronisers on the pin inputs
`timescale 1ns/1ps
`include "tmc_regs.svh"
`define CHK(nm, e, g) check(nm, 16'(e), 16'(g))

module tmc_timer_bench;
   import tmc_pkg::*;

   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] com; // compare output mode for channel a
      logic init; // preset output state
      logic expd; // state after a forced compare
   } tmc_row_t;
   logic clock = 1'b0; // system clock
   logic reset = 1'b1; // synchronous reset, held at start
   tmc_bus_t bus = '0; // register port strobes
   logic [15:0] rdata; // read data, cycle after strobe
   logic ovfIntAck = 1'b0; // overflow interrupt taken
   logic captureEvent = 1'b0; // capture input level
   logic portOutA = 1'b0; // general port bits
   logic portOutB = 1'b0;
   logic pinDirA = 1'b0; // pin directions, 1 = output
   logic pinDirB = 1'b0;
   logic pinOutA;
   logic pinOutEnA_n;
   logic pinOutB;
   logic pinOutEnB_n;
   logic prevPin; // last sampled pin level
   logic [15:0] got; // last read value
   int errorCnt = 0; // mismatches seen
   int samplesChecked = 0; // comparisons made
   int cycleCnt = 0; // run length guard
   int edges; // pin toggles counted
   int divs [5] = '{1, 8, 64, 256, 1024}; // prescale factors by select 1..5
   // forced actions: none, toggle from both levels, clear, set
   tmc_row_t rows [5] = '{'{2'h0, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b1}, '{2'h1, 1'b1, 1'b0},
                          '{2'h2, 1'b1, 1'b0}, '{2'h3, 1'b0, 1'b1}};

   always #5 clock = ~clock; // 100 MHz

   tmc_timer uut (
      .clock(clock),
      .reset(reset),
      .bus(bus),
      .rdata(rdata),
      .ovfIntAck(ovfIntAck),
      .captureEvent(captureEvent),
      .portOutA(portOutA),
      .portOutB(portOutB),
      .pinDirA(pinDirA),
      .pinDirB(pinDirB),
      .pinOutA(pinOutA),
      .pinOutEnA_n(pinOutEnA_n),
      .pinOutB(pinOutB),
      .pinOutEnB_n(pinOutEnB_n)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      samplesChecked++;
      if (g !== e) begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // one-cycle write, then a quiet cycle so strobes never get two assignments at one edge
   task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clock);
      bus <= '0;
      @(posedge clock);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic regRead(input logic [3:0] a, output logic [15:0] d);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clock);
      bus <= '0;
      #1 d = rdata;
      @(posedge clock);
   endtask

   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // hang guard: the whole run needs roughly 11200 cycles
   always @(posedge clock) begin
      cycleCnt++;
      if (cycleCnt == 20000) begin
         errorCnt++;
         $display("BAD timeout expected finish seen hang");
         giveVerdict();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      tick(2);
      reset <= 1'b0;
      @(posedge clock);
      // forced compare table, timer stopped so only the force can act
      foreach (rows[i]) begin
         regWrite(`TMC_ADDR_STATE, {15'h0, rows[i].init});
         regWrite(`TMC_ADDR_CTRL, {6'h0, rows[i].com, 8'h00});
         regWrite(`TMC_ADDR_FORCE, 16'h0001);
         regRead(`TMC_ADDR_STATE, got);
         `CHK("forced state a", rows[i].expd, got[0]);
         regRead(`TMC_ADDR_FLAGS, got);
         `CHK("flag a after force", 1'b0, got[1]);
      end
      $display("test force table done");
      // pin override needs a nonzero mode and the select bit; direction stays with the port
      pinDirA <= 1'b1;
      portOutA <= 1'b1;
      pinDirB <= 1'b1;
      portOutB <= 1'b1;
      regWrite(`TMC_ADDR_STATE, 16'h0000);
      regWrite(`TMC_ADDR_CTRL, 16'h0100);
      tick(6);
      `CHK("pin a port bit", 1'b1, pinOutA);
      `CHK("pin a enable", 1'b0, pinOutEnA_n);
      `CHK("pin b port bit", 1'b1, pinOutB);
      `CHK("pin b enable", 1'b0, pinOutEnB_n);
      regWrite(`TMC_ADDR_OUTSEL, 16'h0001);
      tick(3);
      `CHK("pin a preset state", 1'b0, pinOutA);
      regWrite(`TMC_ADDR_CTRL, 16'h0000);
      tick(3);
      `CHK("pin a mode zero", 1'b1, pinOutA);
      pinDirA <= 1'b0;
      tick(6);
      `CHK("pin a input dir", 1'b1, pinOutEnA_n);
      $display("test pin override done");
      // normal mode wrap sets the overflow flag, taking the interrupt clears it
      regWrite(`TMC_ADDR_FLAGS, 16'h000f);
      regWrite(`TMC_ADDR_COUNT, 16'hfff0);
      regWrite(`TMC_ADDR_CTRL, 16'h0001);
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("overflow early", 1'b0, got[`TMC_FLAG_OVF]);
      tick(20);
      regWrite(`TMC_ADDR_CTRL, 16'h0000);
      regRead(`TMC_ADDR_COUNT, got);
      `CHK("wrapped count", 1'b1, got != 16'h0000 && got < 16'h0030);
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("overflow set", 1'b1, got[`TMC_FLAG_OVF]);
      ovfIntAck <= 1'b1;
      @(posedge clock);
      ovfIntAck <= 1'b0;
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("overflow taken", 1'b0, got[`TMC_FLAG_OVF]);
      $display("test normal wrap done");
      // clear on compare a, toggling the pin every top+1 ticks
      pinDirA <= 1'b1;
      regWrite(`TMC_ADDR_CMPA, 16'h0003);
      regWrite(`TMC_ADDR_COUNT, 16'h0000);
      regWrite(`TMC_ADDR_CTRL, 16'h0141);
      tick(10);
      edges = 0;
      prevPin = pinOutA;
      repeat (80) begin
         @(posedge clock);
         #1;
         if (pinOutA !== prevPin) edges++;
         prevPin = pinOutA;
      end
      @(posedge clock);
      regWrite(`TMC_ADDR_CTRL, 16'h0000);
      `CHK("toggle count", 1'b1, edges >= 19 && edges <= 21);
      regRead(`TMC_ADDR_COUNT, got);
      `CHK("count below top", 1'b1, got <= 16'h0003);
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("top flag a", 1'b1, got[`TMC_FLAG_CMPA]);
      // count written above the top: match missed, counter runs on
      regWrite(`TMC_ADDR_COUNT, 16'h0010);
      regWrite(`TMC_ADDR_CTRL, 16'h0041);
      tick(20);
      regWrite(`TMC_ADDR_CTRL, 16'h0000);
      regRead(`TMC_ADDR_COUNT, got);
      `CHK("missed top runs on", 1'b1, got > 16'h0010);
      $display("test clear on compare a done");
      // clear on capture register top, with output mode set to show it leaves capture alone
      regWrite(`TMC_ADDR_FLAGS, 16'h000f);
      regWrite(`TMC_ADDR_CAPT, 16'h0005);
      regWrite(`TMC_ADDR_COUNT, 16'h0000);
      regWrite(`TMC_ADDR_CTRL, 16'h0fc1);
      tick(30);
      regWrite(`TMC_ADDR_CTRL, 16'h0000);
      regRead(`TMC_ADDR_COUNT, got);
      `CHK("count below capture top", 1'b1, got <= 16'h0005);
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("top flag capture", 1'b1, got[`TMC_FLAG_CAPT]);
      regWrite(`TMC_ADDR_FLAGS, 16'h000f);
      regWrite(`TMC_ADDR_CTRL, 16'h0f00);
      captureEvent <= 1'b1;
      tick(6);
      captureEvent <= 1'b0;
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("capture with mode set", 1'b1, got[`TMC_FLAG_CAPT]);
      $display("test clear on capture done");
      // a counter write equal to the compare value hides that match
      regWrite(`TMC_ADDR_FLAGS, 16'h000f);
      regWrite(`TMC_ADDR_CMPA, 16'h0020);
      regWrite(`TMC_ADDR_COUNT, 16'h0020);
      regWrite(`TMC_ADDR_CTRL, 16'h0041);
      tick(10);
      regWrite(`TMC_ADDR_CTRL, 16'h0000);
      regRead(`TMC_ADDR_COUNT, got);
      `CHK("blocked match count", 1'b1, got > 16'h0020);
      regRead(`TMC_ADDR_FLAGS, got);
      `CHK("blocked match flag", 1'b0, got[`TMC_FLAG_CMPA]);
      $display("test match blocking done");
      // prescaler: eight timer ticks at each factor, small slack for start and stop
      foreach (divs[i]) begin
         regWrite(`TMC_ADDR_COUNT, 16'h0000);
         regWrite(`TMC_ADDR_CTRL, 16'(i + 1));
         tick(divs[i] * 8);
         regWrite(`TMC_ADDR_CTRL, 16'h0000);
         regRead(`TMC_ADDR_COUNT, got);
         `CHK("prescaled count", 1'b1, got >= 16'h0007 && got <= 16'h000a);
      end
      $display("test prescaler done");
      // reset in mid-run clears the output states
      regWrite(`TMC_ADDR_STATE, 16'h0003);
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      @(posedge clock);
      regRead(`TMC_ADDR_STATE, got);
      `CHK("state after reset", 16'h0000, got);
      regRead(`TMC_ADDR_CTRL, got);
      `CHK("ctrl after reset", `TMC_CTRL_RESET, got);
      $display("test reset done");
      giveVerdict();
   end

endmodule // tmc_timer_bench
